/* design/servo_cmd_decoder.sv */
// Purpose: serial command receiver and switch decoder of a servo processor
// Assumes: comparator results arrive as digital levels from analog front end
// Notes:   link pins are sampled by mclk; serial clock must be slow vs mclk
`timescale 1ns/1ps
`include "servo_cmd_cfg.svh"
module servo_cmd_decoder (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // host serial link
  input  wire logic       latch_clear_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_data,
  input  wire logic       load_strobe_n,
  input  wire logic       jump_direction_in,
  // comparator levels
  input  wire logic       focus_error_nonneg,
  input  wire logic       track_error_pos,
  input  wire logic       shock_input_over,
  input  wire logic       mirror_in,
  // focus switches
  output logic            search_up_sw,
  output logic            search_on_sw,
  output logic            focus_gain_down_sw,
  output logic            focus_on_sw,
  // tracking switches
  output logic            track_gain_sw_a,
  output logic            track_gain_sw_b,
  output logic            brake_sw,
  output logic      [5:0] pulse_servo_switches,
  // status
  output logic            status_out,
  output logic            track_count_out
);
  localparam int NPINS = 9;

  logic             rst_meta_r;
  logic             rst_r;
  logic [NPINS-1:0] pins_raw;
  logic [NPINS-1:0] pins_s;
  logic             clr_n_s;
  logic             sclk_s;
  logic             sdata_s;
  logic             strobe_n_s;
  logic             jump_direction_level;
  logic             fzc_s;
  logic             tzc_s;
  logic             shock_detect;
  logic             mirror_s;
  logic             sclk_d_r;
  logic             tzc_d_r;
  logic [`CMD_WIDTH-1:0] shift_r;
  logic [3:0]       focus_latch_r;
  logic [3:0]       track_ctrl_latch_r;
  logic [3:0]       mode_latch_r;
  logic [3:0]       status_addr_r;
  logic             track_count_r;
  logic [5:0]       pulse_nxt;
  logic [3:0]       cmd_addr;
  logic [3:0]       cmd_data;
  logic             load_now;
  logic             anti_shock_active;
  logic             gain_a_nxt;
  logic             gain_b_nxt;
  logic             tzc_edge;
  logic             dir_d_r;
  logic             jump_done_r;
  logic [3:0]       mode_eff;
  logic             focus_we;
  logic             ctrl_we;
  logic             mode_we;
  logic             status_nxt;

  // reset release through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_r      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_r      <= rst_meta_r;
    end
  end

  assign pins_raw = {mirror_in, shock_input_over, track_error_pos, focus_error_nonneg,
                     jump_direction_in, load_strobe_n, serial_data, serial_clk,
                     latch_clear_n};

  pin_sync #(
    .WIDTH (NPINS)
  ) u_sync (
    .mclk         (mclk),
    .rst_n        (rst_r),
    .pin_in       (pins_raw),
    .pin_sync_out (pins_s)
  );

  assign clr_n_s              = pins_s[0];
  assign sclk_s               = pins_s[1];
  assign sdata_s              = pins_s[2];
  assign strobe_n_s           = pins_s[3];
  assign jump_direction_level = pins_s[4];
  assign fzc_s                = pins_s[5];
  assign tzc_s                = pins_s[6];
  assign shock_detect         = pins_s[7];
  assign mirror_s             = pins_s[8];

  // synchroniser resets to zero; the serial clock and direction detectors start high,
  // so each sees one fall in the first cycle after reset; the zero-cross one starts low
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      sclk_d_r <= 1'b1;
      tzc_d_r  <= 1'b0;
      dir_d_r  <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      tzc_d_r  <= tzc_s;
      dir_d_r  <= jump_direction_level;
    end
  end

  function automatic logic [3:0] addr_of(input logic [`CMD_WIDTH-1:0] w);
    addr_of = w[`CMD_ADDR_HI:`CMD_ADDR_LO];
  endfunction

  assign cmd_addr = addr_of(shift_r);
  assign cmd_data = shift_r[`CMD_DATA_HI:`CMD_DATA_LO];
  // level-sensitive load; clear input overrides it
  assign load_now = !strobe_n_s && clr_n_s;

  // one compare per latch; undefined addresses enable nothing
  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] sel);
    addr_hit = (a == sel);
  endfunction

  assign focus_we = load_now && addr_hit(cmd_addr, `ADDR_FOCUS);
  assign ctrl_we  = load_now && addr_hit(cmd_addr, `ADDR_TRACK_CTRL);
  assign mode_we  = load_now && addr_hit(cmd_addr, `ADDR_TRACK_MODE);

  // shift register: lsb first, so each bit enters at the top
  // extra bits are not refused: only the last eight are kept
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      shift_r <= `CMD_RESET;
    else if (!clr_n_s)
      shift_r <= `CMD_RESET;
    else if (sclk_d_r && !sclk_s)
      shift_r <= {sdata_s, shift_r[`CMD_WIDTH-1:1]};
  end

  // focus latch
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      focus_latch_r <= `LATCH_RESET;
    else if (!clr_n_s)
      focus_latch_r <= `LATCH_RESET;
    else if (focus_we)
      focus_latch_r <= cmd_data;
  end

  // tracking gain and brake latch
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      track_ctrl_latch_r <= `LATCH_RESET;
    else if (!clr_n_s)
      track_ctrl_latch_r <= `LATCH_RESET;
    else if (ctrl_we)
      track_ctrl_latch_r <= cmd_data;
  end

  // tracking and sled mode latch
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      mode_latch_r <= `LATCH_RESET;
    else if (!clr_n_s)
      mode_latch_r <= `LATCH_RESET;
    else if (mode_we)
      mode_latch_r <= cmd_data;
  end

  // status selection remembers only defined addresses
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      status_addr_r <= `ADDR_FOCUS;
    else if (!clr_n_s)
      status_addr_r <= `ADDR_FOCUS;
    else if (focus_we || ctrl_we || mode_we)
      status_addr_r <= cmd_addr;
  end

  // switch outputs registered so they carry no decode glitches
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      search_up_sw       <= 1'b0;
      search_on_sw       <= 1'b0;
      focus_gain_down_sw <= 1'b0;
      focus_on_sw        <= 1'b0;
    end
    else
    begin
      // 1 here means current source disconnected
      search_up_sw       <= focus_latch_r[`BIT_SEARCH_UP];
      // 1 here means follower driving, 0 high impedance
      search_on_sw       <= focus_latch_r[`BIT_SEARCH_ON];
      focus_gain_down_sw <= focus_latch_r[`BIT_GAIN_DOWN];
      focus_on_sw        <= focus_latch_r[`BIT_FOCUS_ON];
    end
  end

  assign anti_shock_active = track_ctrl_latch_r[`BIT_ANTI_SHOCK] && shock_detect;
  assign tzc_edge          = tzc_s != tzc_d_r;

  // anti-shock flips both gain switches together
  always_comb
  begin
    gain_a_nxt = track_ctrl_latch_r[`BIT_GAIN_A];
    gain_b_nxt = track_ctrl_latch_r[`BIT_GAIN_B];
    if (anti_shock_active)
    begin
      gain_a_nxt = !gain_a_nxt;
      gain_b_nxt = !gain_b_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
    begin
      track_gain_sw_a <= 1'b0;
      track_gain_sw_b <= 1'b0;
      brake_sw        <= 1'b0;
    end
    else
    begin
      track_gain_sw_a <= gain_a_nxt;
      track_gain_sw_b <= gain_b_nxt;
      brake_sw        <= track_ctrl_latch_r[`BIT_BRAKE];
    end
  end

  // a direction fall during a jump marks the deceleration phase; the
  // rise that ends it hands tracking back to servo while the level stays high, until the next mode
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      jump_done_r <= 1'b0;
    else if (!clr_n_s)
      jump_done_r <= 1'b0;
    else if (mode_latch_r[`MODE_TRACK_HI] && dir_d_r && !jump_direction_level)
      jump_done_r <= 1'b1;
    else if (mode_we)
      jump_done_r <= 1'b0;
  end

  // after the deceleration pulse the tracking field reads as servo on
  always_comb
  begin
    mode_eff = mode_latch_r;
    if (jump_done_r && jump_direction_level && mode_latch_r[`MODE_TRACK_HI])
    begin
      mode_eff[`MODE_TRACK_HI] = 1'b0;
      mode_eff[`MODE_TRACK_LO] = 1'b1;
    end
  end

  jump_pulse_table u_table (
    .mode                 (mode_eff),
    .jump_direction_level (jump_direction_level),
    .pulse_servo_switches (pulse_nxt)
  );

  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      pulse_servo_switches <= 6'h00;
    else
      pulse_servo_switches <= pulse_nxt;
  end

  // status pin multiplexer
  always_comb
  begin
    case (status_addr_r)
      `ADDR_FOCUS:      status_nxt = fzc_s;
      `ADDR_TRACK_CTRL: status_nxt = shock_detect;
      `ADDR_TRACK_MODE: status_nxt = tzc_s;
      default:          status_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      status_out <= 1'b0;
    else
      status_out <= status_nxt;
  end

  // mirror captured on either zero-cross edge; noise between edges ignored
  always_ff @(posedge mclk or negedge rst_r)
  begin
    if (!rst_r)
      track_count_r <= 1'b0;
    else if (tzc_edge)
      track_count_r <= mirror_s;
  end

  assign track_count_out = track_count_r;
endmodule // servo_cmd_decoder

/* design/servo_cmd_cfg.svh */
// Purpose: constants of the servo command decoder
// Assumes: included by bare name
// Notes:   field positions, addresses and reset values
`ifndef SERVO_CMD_CFG_SVH
`define SERVO_CMD_CFG_SVH
`define CMD_WIDTH        8
`define CMD_ADDR_HI      7
`define CMD_ADDR_LO      4
`define CMD_DATA_HI      3
`define CMD_DATA_LO      0
`define ADDR_FOCUS       4'h0
`define ADDR_TRACK_CTRL  4'h1
`define ADDR_TRACK_MODE  4'h2
`define LATCH_RESET      4'h0
`define CMD_RESET        8'h00
`define BIT_SEARCH_UP    0
`define BIT_SEARCH_ON    1
`define BIT_GAIN_DOWN    2
`define BIT_FOCUS_ON     3
`define BIT_GAIN_A       0
`define BIT_GAIN_B       1
`define BIT_BRAKE        2
`define BIT_ANTI_SHOCK   3
`define MODE_TRACK_HI    3
`define MODE_TRACK_LO    2
`define MODE_SLED_HI     1
`define MODE_SLED_LO     0
`endif

/* design/servo_cmd_pkg.sv */
// Purpose: shared types of the servo command decoder
// Assumes: nothing
// Notes:   mode encodings follow the two-bit fields of the mode latch
package servo_cmd_pkg;
  typedef enum logic [1:0] {
    track_off, track_servo, track_fwd_jump, track_rev_jump
  } track_mode_t;
  typedef enum logic [1:0] {
    sled_off, sled_servo, sled_fwd_move, sled_rev_move
  } sled_mode_t;
endpackage

/* design/pin_sync.sv */
// Purpose: two-flop synchroniser for a vector of pins
// Assumes: reset already synchronised
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r       <= '0;
      pin_sync_out <= '0;
    end
    else
    begin
      meta_r       <= pin_in;
      pin_sync_out <= meta_r;
    end
  end
endmodule // pin_sync

/* design/jump_pulse_table.sv */
// Purpose: six pulse/servo switch pattern from mode latch and direction level
// Assumes: inputs are registered, so output is only a decode
// Notes:   bit 0 is the first switch, bit 5 the sixth
`timescale 1ns/1ps
`include "servo_cmd_cfg.svh"
module jump_pulse_table (
  // mode
  input  wire logic [3:0] mode,
  input  wire logic       jump_direction_level,
  // switches
  output logic      [5:0] pulse_servo_switches
);
  servo_cmd_pkg::track_mode_t trk;
  servo_cmd_pkg::sled_mode_t  sld;
  logic [5:0] t_part;
  logic [5:0] s_part;

  always_comb
  begin
    trk = servo_cmd_pkg::track_mode_t'(mode[`MODE_TRACK_HI:`MODE_TRACK_LO]);
    sld = servo_cmd_pkg::sled_mode_t'(mode[`MODE_SLED_HI:`MODE_SLED_LO]);
    // tracking: switch 1 servo, 3/4 jump pulse; low level reverses the pulse
    case (trk)
      servo_cmd_pkg::track_off:      t_part = 6'h00;
      servo_cmd_pkg::track_servo:    t_part = 6'h01;
      servo_cmd_pkg::track_fwd_jump: t_part = jump_direction_level ? 6'h04 : 6'h08;
      servo_cmd_pkg::track_rev_jump: t_part = jump_direction_level ? 6'h08 : 6'h04;
      default:                       t_part = 6'h00;
    endcase
    // sled: switch 2 servo, 5/6 fast feed
    case (sld)
      servo_cmd_pkg::sled_off:      s_part = 6'h00;
      servo_cmd_pkg::sled_servo:    s_part = 6'h02;
      servo_cmd_pkg::sled_fwd_move: s_part = 6'h10;
      servo_cmd_pkg::sled_rev_move: s_part = 6'h20;
      default:                      s_part = 6'h00;
    endcase
    pulse_servo_switches = t_part | s_part;
  end
endmodule // jump_pulse_table

/* verification/servo_cmd_decoder_sva.sv */
// Purpose: port checks of the servo command decoder
// Assumes: bound onto servo_cmd_decoder
// Notes:   windows allow for the two-flop pin synchronisers
`timescale 1ns/1ps
module servo_cmd_checker (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // host side
  input wire logic       latch_clear_n,
  input wire logic       load_strobe_n,
  input wire logic       jump_direction_in,
  input wire logic       track_error_pos,
  // switches
  input wire logic       search_up_sw,
  input wire logic       search_on_sw,
  input wire logic       focus_gain_down_sw,
  input wire logic       focus_on_sw,
  input wire logic       track_gain_sw_a,
  input wire logic       track_gain_sw_b,
  input wire logic       brake_sw,
  input wire logic [5:0] pulse_servo_switches,
  input wire logic       track_count_out
);
  wire [6:0] sw_all = {search_up_sw, search_on_sw, focus_gain_down_sw, focus_on_sw,
                       track_gain_sw_a, track_gain_sw_b, brake_sw};
  wire [4:0] sw_held = {search_up_sw, search_on_sw, focus_gain_down_sw, focus_on_sw, brake_sw};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_reset_quiet: assert property (disable iff (1'b0)
    !reset_n |-> sw_all == 7'h00 && pulse_servo_switches == 6'h00) else $error("not quiet in reset");
  a_clear_zero: assert property (!latch_clear_n [*6]
    |-> sw_all == 7'h00 && pulse_servo_switches == 6'h00) else $error("clear left a latch set");
  a_idle_hold: assert property ((load_strobe_n && latch_clear_n) [*8]
    |=> $stable(sw_held)) else $error("latch moved without strobe");
  a_gain_pair: assert property ((load_strobe_n && latch_clear_n) [*8]
    |=> $stable(track_gain_sw_a ^ track_gain_sw_b)) else $error("gains not inverted together");
  a_track_excl: assert property (!(pulse_servo_switches[0] && |pulse_servo_switches[3:2])
    && !(&pulse_servo_switches[3:2])) else $error("tracking switches overlap");
  a_sled_excl: assert property (!(pulse_servo_switches[1] && |pulse_servo_switches[5:4])
    && !(&pulse_servo_switches[5:4])) else $error("sled switches overlap");
  a_jump_flip: assert property ((|pulse_servo_switches[3:2]) && $changed(jump_direction_in)
    && load_strobe_n |-> ##[1:5] $changed(pulse_servo_switches[3:2]))
    else $error("direction change did not flip jump pulse");
  a_count_quiet: assert property ($stable(track_error_pos) [*6]
    |=> $stable(track_count_out)) else $error("track count moved without zero cross");
endmodule // servo_cmd_checker

bind servo_cmd_decoder servo_cmd_checker chk_u (.mclk, .reset_n, .latch_clear_n, .load_strobe_n,
  .jump_direction_in, .track_error_pos, .search_up_sw, .search_on_sw, .focus_gain_down_sw,
  .focus_on_sw, .track_gain_sw_a, .track_gain_sw_b, .brake_sw, .pulse_servo_switches,
  .track_count_out);

/* verification/host_link_model.sv */
// Purpose: host controller side of the serial command link
// Assumes: mclk only paces the model
// Notes:   serial clock rests high outside frames, period 160 ns
`timescale 1ns/1ps
module host_link_model (
  // clock
  input  wire logic mclk,
  // serial link
  output logic      serial_clk,
  output logic      serial_data,
  output logic      load_strobe_n
);
  initial
  begin
    serial_clk    = 1'b1;
    serial_data   = 1'b1;
    load_strobe_n = 1'b1;
  end
  task automatic send(input logic [7:0] cmd);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk);
      serial_data = cmd[i];
      repeat (5) @(negedge mclk);
      serial_clk = 1'b0;
      repeat (10) @(negedge mclk);
      serial_clk = 1'b1;
      repeat (4) @(negedge mclk);
    end
    // released line must not look like the last bit
    serial_data = ~cmd[7];
    load_strobe_n = 1'b0;
    repeat (5) @(negedge mclk);
    load_strobe_n = 1'b1;
    repeat (8) @(negedge mclk);
  endtask
endmodule // host_link_model

/* verification/servo_serial_command_decoder_bench.sv */
// Purpose: self-checking bench of the servo command decoder
// Assumes: host_link_model shifts and strobes commands
// Notes:   comparator levels are plain inputs driven here
`timescale 1ns/1ps
module servo_serial_command_decoder_bench;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b1;
  logic       latch_clear_n = 1'b1;
  logic       jump_direction_in = 1'b1;
  logic       focus_error_nonneg = 1'b0;
  logic       track_error_pos = 1'b0;
  logic       shock_input_over = 1'b0;
  logic       mirror_in = 1'b0;
  logic       serial_clk, serial_data, load_strobe_n;
  logic       search_up_sw, search_on_sw, focus_gain_down_sw, focus_on_sw;
  logic       track_gain_sw_a, track_gain_sw_b, brake_sw, status_out, track_count_out;
  logic [5:0] pulse_servo_switches;
  int         err_total = 0;
  int         n_checks = 0;
  wire  [7:0] focus_sw = {4'h0, focus_on_sw, focus_gain_down_sw, search_on_sw, search_up_sw};

  always #4 mclk = ~mclk;

  host_link_model host_u (.mclk, .serial_clk, .serial_data, .load_strobe_n);
  servo_cmd_decoder dut_u (.mclk, .reset_n, .latch_clear_n, .serial_clk, .serial_data,
    .load_strobe_n, .jump_direction_in, .focus_error_nonneg, .track_error_pos,
    .shock_input_over, .mirror_in, .search_up_sw, .search_on_sw, .focus_gain_down_sw,
    .focus_on_sw, .track_gain_sw_a, .track_gain_sw_b, .brake_sw, .pulse_servo_switches,
    .status_out, .track_count_out);

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [5:0] exp_pulse(input logic [3:0] m, input logic dc);
    logic [5:0] p;
    p = 6'h00;
    if (m[3:2] == 2'h1)
      p[0] = 1'b1;
    if (m[3])
      p[(m[2] ^ dc) ? 2 : 3] = 1'b1;
    if (m[1:0] != 2'h0)
      p[(m[1:0] == 2'h1) ? 1 : m[1:0] + 2] = 1'b1;
    return p;
  endfunction

  task automatic t_focus();
    for (int c = 0; c < 16; c++)
    begin
      focus_error_nonneg = c[0];
      host_u.send(8'(c));
      chk("focus", 8'(c), focus_sw);
      chk("fzc", {7'h00, c[0]}, {7'h00, status_out});
    end
    for (int k = 0; k < 4; k++)
    begin
      host_u.send(8'h02 | 8'(k & 1));
      chk("search up", 8'(k & 1), {7'h00, search_up_sw});
      chk("search on", 8'h01, {7'h00, search_on_sw});
    end
    $display("focus test done");
  endtask

  task automatic t_ctrl();
    logic [3:0] d;
    for (int c = 0; c < 32; c++)
    begin
      d = c[3:0];
      shock_input_over = c[4];
      host_u.send({4'h1, d});
      chk("gain", {6'h00, d[1:0] ^ {2{d[3] & c[4]}}}, {6'h00, track_gain_sw_b, track_gain_sw_a});
      chk("brake", {7'h00, d[2]}, {7'h00, brake_sw});
      chk("shock", {7'h00, c[4]}, {7'h00, status_out});
    end
    $display("control test done");
  endtask

  task automatic t_mode();
    logic [3:0] m;
    for (int c = 0; c < 32; c++)
    begin
      jump_direction_in = 1'b1;
      host_u.send({4'h2, 4'(c)});
      jump_direction_in = ~c[4];
      track_error_pos = c[0];
      repeat (8) @(negedge mclk);
      chk("pulse", {2'h0, exp_pulse(4'(c), ~c[4])}, {2'h0, pulse_servo_switches});
      chk("tzc", {7'h00, c[0]}, {7'h00, status_out});
      if (c[4])
      begin
        // direction back high: a jump falls back to tracking servo
        jump_direction_in = 1'b1;
        repeat (8) @(negedge mclk);
        m = c[3] ? {2'h1, c[1:0]} : c[3:0];
        chk("servo return", {2'h0, exp_pulse(m, 1'b1)}, {2'h0, pulse_servo_switches});
      end
    end
    $display("mode test done");
  endtask

  task automatic t_undef();
    track_error_pos = 1'b0;
    focus_error_nonneg = 1'b1;
    host_u.send(8'h0B);
    host_u.send(8'h35);
    host_u.send(8'hF0);
    chk("undef focus", 8'h0B, focus_sw);
    // mode F was left after its jump ended, so tracking is back on servo
    chk("undef mode", {2'h0, exp_pulse(4'h7, 1'b1)}, {2'h0, pulse_servo_switches});
    chk("undef status", 8'h01, {7'h00, status_out});
    $display("undefined address test done");
  endtask

  task automatic t_clear();
    latch_clear_n = 1'b0;
    host_u.send(8'h0F);
    latch_clear_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("clear focus", 8'h00, focus_sw);
    chk("clear pulse", 8'h00, {2'h0, pulse_servo_switches});
    $display("clear test done");
  endtask

  task automatic t_count();
    for (int c = 0; c < 4; c++)
    begin
      mirror_in = (c != 1);
      repeat (3) @(negedge mclk);
      track_error_pos = ~track_error_pos;
      repeat (8) @(negedge mclk);
      chk("count", {7'h00, c != 1}, {7'h00, track_count_out});
      mirror_in = (c == 1);
      repeat (8) @(negedge mclk);
      chk("count hold", {7'h00, c != 1}, {7'h00, track_count_out});
    end
    $display("count test done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    // a real falling edge, so the asynchronous reset fires at once
    #1;
    reset_n = 1'b0;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    repeat (6) @(negedge mclk);
    t_focus();
    t_ctrl();
    t_mode();
    t_undef();
    t_clear();
    t_count();
    summarize();
  end

  // about 90 commands of some 180 cycles each
  initial
  begin
    #400000;
    err_total++;
    summarize();
  end
endmodule // servo_serial_command_decoder_bench
